// ==== common/usc_pkg.sv ====
// package: register map, field positions, modes and states of the serial core
package usc_pkg;
  // register byte offsets on the axi4-lite slave
  localparam logic [5:0] OFS_CSA  = 6'h00;
  localparam logic [5:0] OFS_CSB  = 6'h04;
  localparam logic [5:0] OFS_CSC  = 6'h08;
  localparam logic [5:0] OFS_BDL  = 6'h0c;
  localparam logic [5:0] OFS_BDH  = 6'h10;
  localparam logic [5:0] OFS_DATA = 6'h14;
  // ctrl_status_a fields
  localparam int CSA_DS   = 1;
  localparam int CSA_PE   = 2;
  localparam int CSA_DOR  = 3;
  localparam int CSA_FE   = 4;
  localparam int CSA_TXE  = 5;
  localparam int CSA_RXA  = 7;
  // ctrl_status_b fields
  localparam int CSB_TX8  = 0;
  localparam int CSB_RX8  = 1;
  localparam int CSB_CS2  = 2;
  localparam int CSB_TXEN = 3;
  localparam int CSB_RXEN = 4;
  // ctrl_status_c fields
  localparam int CSC_POL  = 0;
  localparam int CSC_CS0  = 1;
  localparam int CSC_STOP = 3;
  localparam int CSC_PM0  = 4;
  localparam int CSC_SYNC = 6;
  localparam int CSC_XDIR = 7;
  // reset values of the control fields
  localparam logic [7:0]  RST_BYTE = 8'h00;
  localparam logic [11:0] RST_DIV  = 12'h000;
  // frame format encodings
  localparam logic [2:0] CS_NINE   = 3'h7;
  localparam logic [3:0] BITS_BASE = 4'h5;
  localparam logic [3:0] BITS_NINE = 4'h9;
  localparam logic [1:0] PM_OFF    = 2'h0;
  localparam logic [1:0] PM_EVEN   = 2'h2;
  localparam logic [1:0] PM_ODD    = 2'h3;
  // divide-by-16 / divide-by-8 prescale tops and mid-bit sample points
  localparam logic [3:0] PRE_NORM  = 4'hf;
  localparam logic [3:0] PRE_DBL   = 4'h7;
  localparam logic [3:0] MID_NORM  = 4'h7;
  localparam logic [3:0] MID_DBL   = 4'h3;
  // axi responses
  localparam logic [1:0] RESP_OK   = 2'h0;
  localparam logic [1:0] RESP_ERR  = 2'h2;

  typedef struct packed {
    logic       sync_select;
    logic       xfer_clock_direction;
    logic       sync_clock_polarity;
    logic       double_speed;
    logic [2:0] char_size_field;
    logic [1:0] parity_mode_field;
    logic       stop_bit_count_select;
  } usc_cfg_s;

  typedef struct packed {
    logic [8:0] data;
    logic       frame_error;
    logic       parity_error;
  } usc_rx_s;

  typedef enum logic [4:0] {
    TX_IDLE  = 5'h01,
    TX_START = 5'h02,
    TX_DATA  = 5'h04,
    TX_PAR   = 5'h08,
    TX_STOP  = 5'h10
  } usc_tx_e;

  typedef enum logic [4:0] {
    RX_IDLE  = 5'h01,
    RX_START = 5'h02,
    RX_DATA  = 5'h04,
    RX_PAR   = 5'h08,
    RX_STOP  = 5'h10
  } usc_rx_e;
endpackage

// ==== hdl/usc_core.sv ====
// serial transceiver core: baud generator, clock modes, frame tx/rx, axi4-lite registers
// Summary of operation
// - counter reloads at zero or low-byte write
// - one tick per counter zero
// - tx divides tick by 16, 8, 2
// - rx recovery steps on tick, 16/8 states
// - divisor is twelve bits wide
// - sync select; direction picks master or slave
// - double speed only affects asynchronous mode
// - double speed rx uses 8 samples
// - clock pin used only in sync mode
// - slave clock synchronised then edge detected
// - sample on edge opposite output change
// - polarity picks change and sample edges
// - thirty formats: 5-9 bits, parity, stops
// - start, data lsb first, parity, stops
// - next frame at once or idle high
// - tx and rx share one format setting
// - only first stop bit checked for error
// - parity is xor, inverted for odd
// - single write buffer ahead of shifter
// - two-entry rx buffer with error flags
// - size 7 means nine bits, ninth separate
`timescale 1ns/1ns
module usc_core
  import usc_pkg::*;
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [5:0]  s_awaddr,
  input  wire logic        s_awvalid,
  output logic             s_awready,
  input  wire logic [31:0] s_wdata,
  input  wire logic [3:0]  s_wstrb,
  input  wire logic        s_wvalid,
  output logic             s_wready,
  output logic [1:0]       s_bresp,
  output logic             s_bvalid,
  input  wire logic        s_bready,
  input  wire logic [5:0]  s_araddr,
  input  wire logic        s_arvalid,
  output logic             s_arready,
  output logic [31:0]      s_rdata,
  output logic [1:0]       s_rresp,
  output logic             s_rvalid,
  input  wire logic        s_rready,
  input  wire logic        serial_in_pin,
  output logic             serial_out_pin,
  input  wire logic        xck_in,
  output logic             xck_out,
  output logic             xck_oe
);
  usc_cfg_s    cfg_reg;
  logic        tx_en_reg, rx_en_reg, ninth_tx_reg;
  logic [11:0] div_reg;
  logic [5:0]  awaddr_reg;
  logic [31:0] wdata_reg;
  logic        wlane0_reg, aw_held_reg, w_held_reg;
  logic        wr_go, rd_go, wr_bad, bdl_wr, data_wr, data_rd;
  logic [11:0] div_next;
  logic [11:0] baud_cnt_reg;
  logic        tick;
  logic        xs1_reg, xs2_reg, xs3_reg, rs1_reg, rs2_reg, rx_last_reg;
  logic        x_rise, x_fall, tx_step, samp, master;
  logic [3:0]  tx_pre_reg, rx_cnt_reg, pre_top, mid_pt, nbits;
  logic [8:0]  mask;
  usc_tx_e     tx_state_reg;
  logic [8:0]  tx_buf_reg, tx_sh_reg;
  logic        tx_full_reg, tx_par_reg, tx_load, stop_idx_reg;
  logic [3:0]  tx_idx_reg;
  usc_rx_e     rx_state_reg;
  logic [8:0]  rx_sh_reg;
  logic [3:0]  rx_idx_reg;
  logic        rx_pe_reg, rx_push, dor_reg;
  usc_rx_s     rx_mem [2];
  logic        rx_wp_reg, rx_rp_reg;
  logic [1:0]  rx_cnt_q_reg;
  usc_rx_s     rx_head;

  // shared format decode: one setting serves both directions
  assign nbits   = (cfg_reg.char_size_field == CS_NINE) ? BITS_NINE
                   : BITS_BASE + {2'h0, cfg_reg.char_size_field[1:0]};
  assign mask    = ~(9'h1ff << nbits);
  assign master  = cfg_reg.sync_select && cfg_reg.xfer_clock_direction;
  // double speed ignored when synchronous
  assign pre_top = (cfg_reg.double_speed && !cfg_reg.sync_select) ? PRE_DBL : PRE_NORM;
  assign mid_pt  = (cfg_reg.double_speed && !cfg_reg.sync_select) ? MID_DBL : MID_NORM;
  assign rx_head = rx_mem[rx_rp_reg];

  // axi write: address and data held independently, done when both present
  assign wr_go   = aw_held_reg && w_held_reg && !s_bvalid;
  assign wr_bad  = awaddr_reg > OFS_DATA || awaddr_reg[1:0] != 2'h0;
  assign bdl_wr  = wr_go && wlane0_reg && awaddr_reg == OFS_BDL;
  assign data_wr = wr_go && wlane0_reg && awaddr_reg == OFS_DATA;
  assign rd_go   = s_arvalid && s_arready;
  assign data_rd = rd_go && s_araddr == OFS_DATA;
  assign div_next = {div_reg[11:8], wdata_reg[7:0]};

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_reg <= 1'b0;
      w_held_reg  <= 1'b0;
      awaddr_reg  <= 6'h00;
      wdata_reg   <= 32'h0000_0000;
      wlane0_reg  <= 1'b0;
      s_awready   <= 1'b0;
      s_wready    <= 1'b0;
      s_bvalid    <= 1'b0;
      s_bresp     <= RESP_OK;
    end else begin
      s_awready <= !aw_held_reg && !(s_awvalid && s_awready);
      s_wready  <= !w_held_reg && !(s_wvalid && s_wready);
      if (s_awvalid && s_awready) begin
        aw_held_reg <= 1'b1;
        awaddr_reg  <= s_awaddr;
      end
      if (s_wvalid && s_wready) begin
        w_held_reg <= 1'b1;
        wdata_reg  <= s_wdata;
        wlane0_reg <= s_wstrb[0];
      end
      if (wr_go) begin
        aw_held_reg <= 1'b0;
        w_held_reg  <= 1'b0;
        s_bvalid    <= 1'b1;
        s_bresp     <= wr_bad ? RESP_ERR : RESP_OK;
      end else if (s_bready) begin
        s_bvalid <= 1'b0;
      end
    end
  end

  // control registers; only byte lane 0 carries data
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cfg_reg      <= '0;
      tx_en_reg    <= 1'b0;
      rx_en_reg    <= 1'b0;
      ninth_tx_reg <= 1'b0;
      div_reg      <= RST_DIV;
    end else if (wr_go && wlane0_reg) begin
      case (awaddr_reg)
        OFS_CSA: cfg_reg.double_speed <= wdata_reg[CSA_DS];
        OFS_CSB: begin
          ninth_tx_reg                <= wdata_reg[CSB_TX8];
          cfg_reg.char_size_field[2]  <= wdata_reg[CSB_CS2];
          tx_en_reg                   <= wdata_reg[CSB_TXEN];
          rx_en_reg                   <= wdata_reg[CSB_RXEN];
        end
        OFS_CSC: begin
          cfg_reg.sync_clock_polarity     <= wdata_reg[CSC_POL];
          cfg_reg.char_size_field[1:0]    <= wdata_reg[CSC_CS0 +: 2];
          cfg_reg.stop_bit_count_select   <= wdata_reg[CSC_STOP];
          cfg_reg.parity_mode_field       <= wdata_reg[CSC_PM0 +: 2];
          cfg_reg.sync_select             <= wdata_reg[CSC_SYNC];
          cfg_reg.xfer_clock_direction    <= wdata_reg[CSC_XDIR];
        end
        OFS_BDL: div_reg <= div_next;
        OFS_BDH: div_reg[11:8] <= wdata_reg[3:0];
        default: ;
      endcase
    end
  end

  // axi read: answer one cycle after the address is taken
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_arready <= 1'b0;
      s_rvalid  <= 1'b0;
      s_rdata   <= 32'h0000_0000;
      s_rresp   <= RESP_OK;
    end else begin
      s_arready <= !s_rvalid && !rd_go;
      if (rd_go) begin
        s_rvalid <= 1'b1;
        s_rresp  <= RESP_OK;
        s_rdata  <= 32'h0000_0000;
        case (s_araddr)
          OFS_CSA: begin
            s_rdata[CSA_DS]  <= cfg_reg.double_speed;
            s_rdata[CSA_PE]  <= rx_head.parity_error;
            s_rdata[CSA_DOR] <= dor_reg;
            s_rdata[CSA_FE]  <= rx_head.frame_error;
            s_rdata[CSA_TXE] <= !tx_full_reg;
            s_rdata[CSA_RXA] <= rx_cnt_q_reg != 2'h0;
          end
          OFS_CSB: s_rdata[7:0] <= {3'h0, rx_en_reg, tx_en_reg, cfg_reg.char_size_field[2],
                                    rx_head.data[8], ninth_tx_reg};
          OFS_CSC: s_rdata[7:0] <= {cfg_reg.xfer_clock_direction, cfg_reg.sync_select,
                                    cfg_reg.parity_mode_field, cfg_reg.stop_bit_count_select,
                                    cfg_reg.char_size_field[1:0], cfg_reg.sync_clock_polarity};
          OFS_BDL: s_rdata[7:0] <= div_reg[7:0];
          OFS_BDH: s_rdata[3:0] <= div_reg[11:8];
          OFS_DATA: s_rdata[7:0] <= rx_head.data[7:0];
          default: s_rresp <= RESP_ERR;
        endcase
      end else if (s_rready) begin
        s_rvalid <= 1'b0;
      end
    end
  end

  // baud down-counter; a low-byte write restarts it with the new value
  assign tick = baud_cnt_reg == 12'h000;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      baud_cnt_reg <= RST_DIV;
    end else if (bdl_wr) begin
      baud_cnt_reg <= div_next;
    end else if (tick) begin
      baud_cnt_reg <= div_reg;
    end else begin
      baud_cnt_reg <= baud_cnt_reg - 12'h001;
    end
  end

  // pin synchronisers; xs3 only feeds the slave edge detector
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      xs1_reg <= 1'b0;
      xs2_reg <= 1'b0;
      xs3_reg <= 1'b0;
      rs1_reg <= 1'b1;
      rs2_reg <= 1'b1;
    end else begin
      xs1_reg <= xck_in;
      xs2_reg <= xs1_reg;
      xs3_reg <= xs2_reg;
      rs1_reg <= serial_in_pin;
      rs2_reg <= rs1_reg;
    end
  end

  // master toggles the clock pin per tick, so one bit spans two ticks
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      xck_out <= 1'b0;
      xck_oe  <= 1'b0;
    end else begin
      xck_oe <= master;
      if (!master) begin
        xck_out <= cfg_reg.sync_clock_polarity;
      end else if (tick) begin
        xck_out <= !xck_out;
      end
    end
  end

  // edge pulses; slave relies on the peer clock staying under a quarter of aclk
  assign x_rise = master ? (tick && !xck_out) : (xs2_reg && !xs3_reg);
  assign x_fall = master ? (tick && xck_out) : (!xs2_reg && xs3_reg);
  // change on one edge, sample on the other
  assign tx_step = cfg_reg.sync_select ? (cfg_reg.sync_clock_polarity ? x_fall : x_rise)
                   : (tick && tx_pre_reg == 4'h0);
  assign samp    = cfg_reg.sync_select ? (cfg_reg.sync_clock_polarity ? x_rise : x_fall)
                   : (tick && rx_cnt_reg == mid_pt);

  // transmit prescaler divides ticks by 16 or 8
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tx_pre_reg <= 4'h0;
    end else if (tick) begin
      tx_pre_reg <= (tx_pre_reg == 4'h0) ? pre_top : tx_pre_reg - 4'h1;
    end
  end

  // single write buffer ahead of the shifter; a new write beats a load
  assign tx_load = tx_step && tx_full_reg && tx_en_reg
                   && (tx_state_reg == TX_IDLE
                       || (tx_state_reg == TX_STOP && !(cfg_reg.stop_bit_count_select && !stop_idx_reg)));
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tx_full_reg <= 1'b0;
      tx_buf_reg  <= 9'h000;
    end else if (data_wr) begin
      tx_full_reg <= 1'b1;
      tx_buf_reg  <= {ninth_tx_reg, wdata_reg[7:0]};
    end else if (tx_load) begin
      tx_full_reg <= 1'b0;
    end
  end

  // transmit frame sequencer, steps on tx_step
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tx_state_reg   <= TX_IDLE;
      tx_sh_reg      <= 9'h000;
      tx_idx_reg     <= 4'h0;
      tx_par_reg     <= 1'b0;
      stop_idx_reg   <= 1'b0;
      serial_out_pin <= 1'b1;
    end else if (tx_load) begin
      tx_sh_reg      <= tx_buf_reg & mask;
      tx_par_reg     <= ^(tx_buf_reg & mask) ^ cfg_reg.parity_mode_field[0];
      tx_idx_reg     <= 4'h0;
      serial_out_pin <= 1'b0;
      tx_state_reg   <= TX_START;
    end else if (tx_step) begin
      case (tx_state_reg)
        TX_START: begin
          serial_out_pin <= tx_sh_reg[0];
          tx_sh_reg      <= tx_sh_reg >> 1;
          tx_state_reg   <= TX_DATA;
        end
        TX_DATA: begin
          stop_idx_reg <= 1'b0;
          if (tx_idx_reg == nbits - 4'h1) begin
            serial_out_pin <= cfg_reg.parity_mode_field[1] ? tx_par_reg : 1'b1;
            tx_state_reg   <= cfg_reg.parity_mode_field[1] ? TX_PAR : TX_STOP;
          end else begin
            serial_out_pin <= tx_sh_reg[0];
            tx_sh_reg      <= tx_sh_reg >> 1;
            tx_idx_reg     <= tx_idx_reg + 4'h1;
          end
        end
        TX_PAR: begin
          serial_out_pin <= 1'b1;
          tx_state_reg   <= TX_STOP;
        end
        TX_STOP: begin
          if (cfg_reg.stop_bit_count_select && !stop_idx_reg) begin
            stop_idx_reg <= 1'b1;
          end else begin
            tx_state_reg <= TX_IDLE;
          end
        end
        default: begin
          serial_out_pin <= 1'b1;
          tx_state_reg   <= TX_IDLE;
        end
      endcase
    end
  end

  // receive recovery counter: 16 or 8 ticks per bit in asynchronous mode
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_cnt_reg  <= 4'h0;
      rx_last_reg <= 1'b1;
    end else if (tick) begin
      rx_last_reg <= rs2_reg;
      if (rx_state_reg == RX_IDLE) begin
        rx_cnt_reg <= 4'h0;
      end else begin
        rx_cnt_reg <= (rx_cnt_reg == pre_top) ? 4'h0 : rx_cnt_reg + 4'h1;
      end
    end
  end

  // receive frame sequencer
  assign rx_push = samp && rx_state_reg == RX_STOP;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_state_reg <= RX_IDLE;
      rx_sh_reg    <= 9'h000;
      rx_idx_reg   <= 4'h0;
      rx_pe_reg    <= 1'b0;
    end else if (!rx_en_reg) begin
      rx_state_reg <= RX_IDLE;
    end else begin
      case (rx_state_reg)
        RX_IDLE: begin
          rx_sh_reg  <= 9'h000;
          rx_idx_reg <= 4'h0;
          rx_pe_reg  <= 1'b0;
          if (cfg_reg.sync_select && samp && !rs2_reg) begin
            rx_state_reg <= RX_DATA;
          end else if (!cfg_reg.sync_select && tick && rx_last_reg && !rs2_reg) begin
            rx_state_reg <= RX_START;
          end
        end
        RX_START: if (samp) begin
          rx_state_reg <= rs2_reg ? RX_IDLE : RX_DATA;
        end
        RX_DATA: if (samp) begin
          rx_sh_reg[rx_idx_reg] <= rs2_reg;
          rx_idx_reg            <= rx_idx_reg + 4'h1;
          if (rx_idx_reg == nbits - 4'h1) begin
            rx_state_reg <= cfg_reg.parity_mode_field[1] ? RX_PAR : RX_STOP;
          end
        end
        RX_PAR: if (samp) begin
          rx_pe_reg    <= rs2_reg ^ (^rx_sh_reg) ^ cfg_reg.parity_mode_field[0];
          rx_state_reg <= RX_STOP;
        end
        RX_STOP: if (samp) begin
          rx_state_reg <= RX_IDLE;
        end
        default: rx_state_reg <= RX_IDLE;
      endcase
    end
  end

  // two-entry receive buffer; push when full drops the char and flags overrun
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_wp_reg    <= 1'b0;
      rx_rp_reg    <= 1'b0;
      rx_cnt_q_reg <= 2'h0;
      dor_reg      <= 1'b0;
      rx_mem[0]    <= '0;
      rx_mem[1]    <= '0;
    end else begin
      if (rx_push && rx_cnt_q_reg != 2'h2) begin
        rx_mem[rx_wp_reg] <= '{data: rx_sh_reg, frame_error: !rs2_reg, parity_error: rx_pe_reg};
        rx_wp_reg         <= !rx_wp_reg;
      end
      if (data_rd && rx_cnt_q_reg != 2'h0) begin
        rx_rp_reg <= !rx_rp_reg;
      end
      rx_cnt_q_reg <= rx_cnt_q_reg + {1'b0, rx_push && rx_cnt_q_reg != 2'h2}
                      - {1'b0, data_rd && rx_cnt_q_reg != 2'h0};
      // overrun set wins over the clear by a data read
      if (rx_push && rx_cnt_q_reg == 2'h2) begin
        dor_reg <= 1'b1;
      end else if (data_rd) begin
        dor_reg <= 1'b0;
      end
    end
  end

  property p_reload;
    @(posedge aclk) disable iff (!aresetn) (tick && !bdl_wr) |=> baud_cnt_reg == $past(div_reg);
  endproperty
  a_reload: assert property (p_reload) else $error("baud counter did not reload");
  property p_tick_gap;
    @(posedge aclk) disable iff (!aresetn) (tick && div_reg != 12'h000 && !bdl_wr) |=> !tick;
  endproperty
  a_tick_gap: assert property (p_tick_gap) else $error("tick repeated too soon");
  property p_tx_div;
    @(posedge aclk) disable iff (!aresetn) (tx_step && !cfg_reg.sync_select) |-> tick && tx_pre_reg == 4'h0;
  endproperty
  a_tx_div: assert property (p_tx_div) else $error("tx step off prescale");
  property p_pin_idle;
    @(posedge aclk) disable iff (!aresetn) !cfg_reg.sync_select |=> !xck_oe;
  endproperty
  a_pin_idle: assert property (p_pin_idle) else $error("clock pin driven in async");
  property p_slave_edge;
    @(posedge aclk) disable iff (!aresetn) (cfg_reg.sync_select && !master && $rose(xs2_reg)) |-> x_rise;
  endproperty
  a_slave_edge: assert property (p_slave_edge) else $error("slave edge missed");
  property p_start_low;
    @(posedge aclk) disable iff (!aresetn) tx_load |=> !serial_out_pin && tx_state_reg == TX_START;
  endproperty
  a_start_low: assert property (p_start_low) else $error("start bit not low");
  property p_idle_high;
    @(posedge aclk) disable iff (!aresetn) tx_state_reg == TX_IDLE |-> serial_out_pin;
  endproperty
  a_idle_high: assert property (p_idle_high) else $error("line not idle high");
  property p_parity;
    @(posedge aclk) disable iff (!aresetn) tx_state_reg == TX_PAR |-> serial_out_pin == tx_par_reg;
  endproperty
  a_parity: assert property (p_parity) else $error("parity bit wrong");
  property p_fe;
    @(posedge aclk) disable iff (!aresetn)
      (rx_push && rx_cnt_q_reg == 2'h0 && !data_rd) |=> rx_head.frame_error == !$past(rs2_reg);
  endproperty
  a_fe: assert property (p_fe) else $error("frame error mismatch");
endmodule

// ==== verif/tb_usc_core.sv ====
// bench: frames both ways, error flags, bus refusal, clock modes
`timescale 1ns/1ns
module tb_usc_core
  import usc_pkg::*;
;
  logic        aclk;
  logic        aresetn = 1'b0;
  logic [5:0]  s_awaddr = 6'h00;
  logic        s_awvalid = 1'b0;
  logic [31:0] s_wdata = 32'h0;
  logic [3:0]  s_wstrb = 4'h1;
  logic        s_wvalid = 1'b0;
  logic        s_bready = 1'b0;
  logic [5:0]  s_araddr = 6'h00;
  logic        s_arvalid = 1'b0;
  logic        s_rready = 1'b0;
  logic        xck_in;
  logic        s_awready, s_wready, s_bvalid, s_arready, s_rvalid;
  logic [1:0]  s_bresp, s_rresp, r;
  logic [31:0] s_rdata, q;
  logic        serial_in_pin, serial_out_pin, xck_out, xck_oe, ds;
  logic [7:0]  c, d, dv;
  logic [12:0] f;
  int          n, len, bt, failures, cmp_count;
  // rows: divisor low, double speed, format byte, data
  logic [24:0] rows [4] = '{{8'h00, 1'b0, 8'h00, 8'hf5}, {8'h00, 1'b0, 8'h26, 8'ha7},
                            {8'h00, 1'b0, 8'h3c, 8'h5b}, {8'h01, 1'b1, 8'h22, 8'h2c}};

  usc_core DUT (.aclk, .aresetn, .s_awaddr, .s_awvalid, .s_awready, .s_wdata, .s_wstrb, .s_wvalid,
    .s_wready, .s_bresp, .s_bvalid, .s_bready, .s_araddr, .s_arvalid, .s_arready, .s_rdata, .s_rresp,
    .s_rvalid, .s_rready, .serial_in_pin, .serial_out_pin, .xck_in, .xck_out, .xck_oe);
  usc_peer peer (.aclk, .tx_line(serial_out_pin), .rx_line(serial_in_pin), .xck_line(xck_in));

  // leading edge keeps a new request off the edge that ended the last one
  task automatic wr(input logic [5:0] a, input logic [7:0] v, output logic [1:0] rs);
    @(posedge aclk);
    s_awaddr <= a;
    s_wdata <= {24'h0, v};
    s_awvalid <= 1'b1;
    s_wvalid <= 1'b1;
    s_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_awready) s_awvalid <= 1'b0;
      if (s_wready) s_wvalid <= 1'b0;
    end while (s_bvalid !== 1'b1);
    rs = s_bresp;
    s_bready <= 1'b0;
  endtask
  task automatic rd(input logic [5:0] a, output logic [31:0] v, output logic [1:0] rs);
    @(posedge aclk);
    s_araddr <= a;
    s_arvalid <= 1'b1;
    s_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_arready) s_arvalid <= 1'b0;
    end while (s_rvalid !== 1'b1);
    v = s_rdata;
    rs = s_rresp;
    s_rready <= 1'b0;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  // expected frame: start, data lsb first, parity, stops
  function automatic logic [12:0] mk(input logic [7:0] v, input logic [7:0] fm);
    logic [12:0] e;
    int nb;
    nb = 5 + fm[2:1];
    e = '1;
    e[0] = 1'b0;
    for (int i = 0; i < nb; i++) e[i+1] = v[i];
    if (fm[5]) e[nb+1] = ^(v & (8'hff >> (8 - nb))) ^ fm[4];
    return e;
  endfunction
  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  initial begin
    aclk = 1'b0;
    forever #25 aclk = ~aclk;
  end
  // generous bound, the run needs some 3000 cycles
  initial begin
    repeat (20000) @(posedge aclk);
    failures++;
    give_verdict();
  end
  initial begin
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    @(negedge aclk);
    chk(32'(serial_out_pin), 32'h1);
    chk(32'(xck_oe), 32'h0);
    wr(OFS_BDH, 8'h00, r);
    wr(OFS_CSB, 8'h18, r);
    foreach (rows[k]) begin
      {dv, ds, c, d} = rows[k];
      n = 5 + c[2:1];
      len = 2 + n + c[5] + c[3];
      bt = (ds ? 8 : 16) * (dv + 1);
      wr(OFS_BDL, dv, r);
      wr(OFS_CSA, {6'h0, ds, 1'b0}, r);
      wr(OFS_CSC, c, r);
      fork
        wr(OFS_DATA, d, r);
        peer.grab(len, bt, f);
      join
      chk(32'(f), 32'(mk(d, c)));
      peer.send(mk(d, c), len, bt);
      repeat (bt) @(posedge aclk);
      rd(OFS_DATA, q, r);
      chk(q, 32'(d & (8'hff >> (8 - n))));
    end
    // three frames left unread: the third overruns the two-entry buffer
    repeat (3) begin
      peer.send(mk(8'h2c, 8'h22), 9, 16);
      repeat (16) @(posedge aclk);
    end
    rd(OFS_CSA, q, r);
    chk(32'(q[CSA_DOR]), 32'h1);
    chk(32'(q[CSA_RXA]), 32'h1);
    rd(OFS_DATA, q, r);
    chk(q, 32'h2c);
    rd(OFS_CSA, q, r);
    chk(32'(q[CSA_DOR]), 32'h0);
    rd(OFS_DATA, q, r);
    // bad parity, bad first stop, bad second stop
    wr(OFS_BDL, 8'h00, r);
    wr(OFS_CSA, 8'h00, r);
    wr(OFS_CSC, 8'h2e, r);
    for (int k = 9; k < 12; k++) begin
      f = mk(8'h3c, 8'h2e);
      f[k] = ~f[k];
      peer.send(f, 12, 16);
      repeat (16) @(posedge aclk);
      rd(OFS_CSA, q, r);
      chk(32'(q[CSA_FE]), 32'(k == 10));
      chk(32'(q[CSA_PE]), 32'(k == 9));
      rd(OFS_DATA, q, r);
    end
    // nine-bit character; its ninth bit comes from the control bit, here zero
    wr(OFS_CSC, 8'h06, r);
    wr(OFS_CSB, 8'h1c, r);
    fork
      wr(OFS_DATA, 8'hc3, r);
      peer.grab(11, 16, f);
    join
    chk(32'(f), 32'(mk(8'hc3, 8'h06) & 13'h1dff));
    wr(OFS_CSB, 8'h18, r);
    wr(6'h3c, 8'h55, r);
    chk(32'(r), 32'(RESP_ERR));
    rd(6'h3c, q, r);
    chk(32'(r), 32'(RESP_ERR));
    // sync master: two aclk per bit at divisor zero
    wr(OFS_CSC, 8'hc6, r);
    fork
      wr(OFS_DATA, 8'h96, r);
      peer.grab(10, 2, f);
    join
    chk(32'(f), 32'(mk(8'h96, 8'h06)));
    chk(32'(xck_oe), 32'h1);
    // master with polarity one: data change moves to the falling edge
    wr(OFS_CSC, 8'hc7, r);
    fork
      wr(OFS_DATA, 8'h69, r);
      peer.grab(10, 2, f);
    join
    chk(32'(f), 32'(mk(8'h69, 8'h06)));
    // slave with polarity one, clocked by the peer at an eighth of aclk
    wr(OFS_CSC, 8'h47, r);
    @(negedge aclk);
    chk(32'(xck_oe), 32'h0);
    chk(32'(xck_out), 32'h1);
    fork
      wr(OFS_DATA, 8'ha5, r);
      peer.grab(10, 8, f);
      peer.run_clock(24, 4);
    join
    chk(32'(f), 32'(mk(8'ha5, 8'h06)));
    wr(OFS_CSC, 8'h07, r);
    @(negedge aclk);
    chk(32'(xck_oe), 32'h0);
    chk(32'(xck_out), 32'h1);
    // second reset in mid-run: pins and status fall back to idle
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    @(negedge aclk);
    chk(32'(serial_out_pin), 32'h1);
    chk(32'(xck_out), 32'h0);
    rd(OFS_CSA, q, r);
    chk(q, 32'h1 << CSA_TXE);
    give_verdict();
  end
endmodule

// ==== verif/usc_peer.sv ====
// behavioural remote serial peer: frames both ways and the slave transfer clock
`timescale 1ns/1ns
module usc_peer (
  input  wire logic aclk,
  input  wire logic tx_line,
  output logic      rx_line,
  output logic      xck_line
);
  // line rests high between frames
  initial rx_line = 1'b1;
  // transfer clock stands still low outside frames
  initial xck_line = 1'b0;
  // slave clock: n toggles, half aclk cycles apart; period kept above four aclk
  task automatic run_clock(input int n, input int half);
    for (int i = 0; i < n; i++) begin
      repeat (half) @(posedge aclk);
      xck_line <= ~xck_line;
    end
  endtask
  // send a prebuilt frame lsb first, bt aclk cycles per bit
  task automatic send(input logic [12:0] f, input int len, input int bt);
    for (int i = 0; i < len; i++) begin
      rx_line <= f[i];
      repeat (bt) @(posedge aclk);
    end
    rx_line <= 1'b1;
  endtask
  // capture a frame from the start edge, sampling mid-bit
  task automatic grab(input int len, input int bt, output logic [12:0] f);
    f = '1;
    @(negedge tx_line);
    repeat (bt / 2) @(posedge aclk);
    for (int i = 0; i < len; i++) begin
      f[i] = tx_line;
      repeat (bt) @(posedge aclk);
    end
  endtask
endmodule
